//--- hw/thermal_boot_supervisor.sv
`timescale 1ns/1ns
module thermal_boot_supervisor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sensors and comparators
    input wire logic [1:0] converter_switch_overtemp,
    input wire logic conn_supply_overtemp,
    input wire logic discharge_path_overtemp,
    input wire logic master_regulator_overtemp,
    input wire logic enable_rising_threshold,
    input wire logic enable_off_below,
    input wire logic supply_valid_threshold,
    // Measurements
    input wire logic [tbs_pkg::ADC_W-1:0] config_select_resistor,
    input wire logic [tbs_pkg::ADC_W-1:0] thermistor_sense,
    input wire logic [tbs_pkg::ADC_W-1:0] port_a_bus_power,
    // Outputs
    output logic converter_enable,
    output logic port_a_conn_supply,
    output logic discharge_switch_closed,
    output logic error_recovery_req,
    output logic processor_reset_n,
    output logic port_b_enable,
    output logic update_mode,
    output logic [1:0] thermal_level
);
    import tbs_pkg::*;

    mode_t mode_reg, mode_next;
    logic [31:0] ctrl_reg;
    logic [ADC_W-1:0] th0_reg, th1_reg, th2_reg, disch_th_reg;
    logic [3:0] index_reg;
    logic [3:0] index_w;
    logic disch_open_reg;
    logic [ADC_W-1:0] vbus_prev_reg;
    logic recov_reg;
    logic master_latch_reg;
    logic wr_pend_reg, rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata_next;

    ntc_policy u_ntc (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .sample(thermistor_sense),
        .th0(th0_reg),
        .th1(th1_reg),
        .th2(th2_reg),
        .level(thermal_level)
    );

    index_decode u_idx (
        .code(config_select_resistor),
        .index(index_w)
    );

    // Bus: zero wait states, always OKAY; unmapped reads return zero
    wire bus_take = hsel && hready && htrans[1] && ce;
    // Field positions: index 19:16, level 13:12, discharge open 11, recovery 10, latch 9
    wire [31:0] status_w = {12'h0, index_reg, 2'h0, thermal_level, disch_open_reg,
                            recov_reg, master_latch_reg, 6'h0, 3'(mode_reg)};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_comb begin
        case (haddr[7:0])
            ADDR_CTRL: rdata_next = ctrl_reg;
            ADDR_STATUS: rdata_next = status_w;
            ADDR_NTC_TH0: rdata_next = {20'h0, th0_reg};
            ADDR_NTC_TH1: rdata_next = {20'h0, th1_reg};
            ADDR_NTC_TH2: rdata_next = {20'h0, th2_reg};
            ADDR_DISCH_TH: rdata_next = {20'h0, disch_th_reg};
            ADDR_BOOT: rdata_next = {28'h0, index_reg};
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h0;
            hrdata <= 32'h0;
        end else if (ce) begin
            wr_pend_reg <= bus_take && hwrite;
            rd_pend_reg <= bus_take && !hwrite;
            if (bus_take) begin
                addr_reg <= haddr[7:0];
            end
            if (bus_take && !hwrite) begin
                hrdata <= rdata_next;
            end
        end
    end

    wire wr_ctrl = wr_pend_reg && (addr_reg == ADDR_CTRL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
            th0_reg <= NTC_TH0_RESET;
            th1_reg <= NTC_TH1_RESET;
            th2_reg <= NTC_TH2_RESET;
            disch_th_reg <= DISCH_TH_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_reg <= {29'h0, hwdata[2:0]};
            end else if (mode_reg == ST_SHUTDOWN) begin
                // Boot handshake bits are meaningless once the processor is held
                ctrl_reg <= CTRL_RESET;
            end
            if (wr_pend_reg && addr_reg == ADDR_NTC_TH0) th0_reg <= hwdata[ADC_W-1:0];
            if (wr_pend_reg && addr_reg == ADDR_NTC_TH1) th1_reg <= hwdata[ADC_W-1:0];
            if (wr_pend_reg && addr_reg == ADDR_NTC_TH2) th2_reg <= hwdata[ADC_W-1:0];
            if (wr_pend_reg && addr_reg == ADDR_DISCH_TH) begin
                disch_th_reg <= hwdata[ADC_W-1:0];
            end
        end
    end

    // Power mode
    wire power_ok = enable_rising_threshold && supply_valid_threshold && !enable_off_below;
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_SHUTDOWN: begin
                if (power_ok && !master_latch_reg) mode_next = ST_MEASURE;
            end
            ST_MEASURE: mode_next = ST_LOAD;
            ST_LOAD: begin
                if (index_reg == UPDATE_INDEX) mode_next = ST_UPDATE;
                else if (ctrl_reg[CTRL_LOAD_ERR]) mode_next = ST_FALLBACK;
                else if (ctrl_reg[CTRL_LOAD_DONE]) mode_next = ST_RUN;
            end
            ST_RUN, ST_FALLBACK, ST_UPDATE: mode_next = mode_reg;
            default: mode_next = ST_SHUTDOWN;
        endcase
        // Leaving power or master over-temperature always wins
        if (enable_off_below || !supply_valid_threshold) mode_next = ST_SHUTDOWN;
        if (master_regulator_overtemp) mode_next = ST_SHUTDOWN;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= ST_SHUTDOWN;
            index_reg <= 4'h0;
            master_latch_reg <= 1'b0;
            processor_reset_n <= 1'b0;
        end else if (ce) begin
            mode_reg <= mode_next;
            if (mode_reg == ST_MEASURE) index_reg <= index_w;
            // Stays latched until the sensor itself clears below hysteresis
            master_latch_reg <= master_regulator_overtemp;
            processor_reset_n <= (mode_next != ST_SHUTDOWN);
        end
    end

    // Error recovery request held until firmware clears it; new event wins over clear
    wire recov_evt = (|converter_switch_overtemp) || conn_supply_overtemp;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            recov_reg <= 1'b0;
        end else if (ce) begin
            if (recov_evt) recov_reg <= 1'b1;
            else if (wr_ctrl && hwdata[CTRL_RECOV_CLR]) recov_reg <= 1'b0;
        end
    end
    assign error_recovery_req = recov_reg;

    // Discharge switch
    wire vbus_falling = port_a_bus_power < vbus_prev_reg;
    wire vbus_above = port_a_bus_power > disch_th_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            disch_open_reg <= 1'b0;
            vbus_prev_reg <= '0;
        end else if (ce) begin
            vbus_prev_reg <= port_a_bus_power;
            if (discharge_path_overtemp) begin
                disch_open_reg <= 1'b1;
            end else if (disch_open_reg && vbus_falling && vbus_above) begin
                disch_open_reg <= 1'b0;
            end
        end
    end

    wire active = (mode_reg != ST_SHUTDOWN);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converter_enable <= 1'b0;
            port_a_conn_supply <= 1'b0;
            discharge_switch_closed <= 1'b0;
            port_b_enable <= 1'b0;
            update_mode <= 1'b0;
        end else if (ce) begin
            converter_enable <= active && !(|converter_switch_overtemp);
            port_a_conn_supply <= active && !conn_supply_overtemp;
            discharge_switch_closed <= active && !discharge_path_overtemp &&
                                       !disch_open_reg;
            port_b_enable <= (mode_reg == ST_RUN);
            update_mode <= (mode_reg == ST_UPDATE);
        end
    end
endmodule : thermal_boot_supervisor

//--- common/tbs_pkg.sv
// Functional notes
// - Either converter switch sensor hot: disable converter, request error recovery.
// - Connector-supply sensor hot: open port A connector-supply switch, request recovery.
// - Discharge sensor hot: keep discharge switch open while hot.
// - After cooling, re-close discharge only on falling bus above firmware threshold.
// - Regulator sensor hot: disable whole device and hard-reset the processor.
// - After master shutdown, resume only once regulator sensor is below hysteresis.
// - Enable comparator below off threshold: stay in shutdown, processor disabled.
// - Active mode only with enable above rising threshold and supply valid.
// - Active start: measure select resistor, decode index, then load configuration.
// - Configuration or patch load error: run with port A only, plain Type-C.
// - Decoded index 8 is the reserved update mode through port A.
// - Three configurable thermistor thresholds give power policy levels, rising is hotter.
package tbs_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_NTC_TH0 = 8'h08;
    localparam logic [7:0] ADDR_NTC_TH1 = 8'h0c;
    localparam logic [7:0] ADDR_NTC_TH2 = 8'h10;
    localparam logic [7:0] ADDR_DISCH_TH = 8'h14;
    localparam logic [7:0] ADDR_BOOT = 8'h18;
    localparam int CTRL_LOAD_DONE = 0;
    localparam int CTRL_LOAD_ERR = 1;
    localparam int CTRL_RECOV_CLR = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [11:0] NTC_TH0_RESET = 12'h800;
    localparam logic [11:0] NTC_TH1_RESET = 12'ha00;
    localparam logic [11:0] NTC_TH2_RESET = 12'hc00;
    localparam logic [11:0] DISCH_TH_RESET = 12'h100;
    localparam logic [3:0] UPDATE_INDEX = 4'h8;
    localparam int ADC_W = 12;
    typedef enum logic [2:0] {
        ST_SHUTDOWN, ST_MEASURE, ST_LOAD, ST_RUN, ST_FALLBACK, ST_UPDATE
    } mode_t;
endpackage : tbs_pkg

//--- hw/ntc_policy.sv
`timescale 1ns/1ns
module ntc_policy (
    // Clock
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Sample and thresholds
    input wire logic [tbs_pkg::ADC_W-1:0] sample,
    input wire logic [tbs_pkg::ADC_W-1:0] th0,
    input wire logic [tbs_pkg::ADC_W-1:0] th1,
    input wire logic [tbs_pkg::ADC_W-1:0] th2,
    // Level, 0 cool to 3 hottest
    output logic [1:0] level
);
    import tbs_pkg::*;
    logic [1:0] level_next;
    // Rising voltage means hotter, so each threshold crossed adds a step
    assign level_next = (sample >= th2) ? 2'h3 : (sample >= th1) ? 2'h2 :
                        (sample >= th0) ? 2'h1 : 2'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= 2'h0;
        end else if (ce) begin
            level <= level_next;
        end
    end
endmodule : ntc_policy

//--- hw/index_decode.sv
`timescale 1ns/1ns
module index_decode (
    // Resistor measurement code
    input wire logic [tbs_pkg::ADC_W-1:0] code,
    // Decoded index
    output logic [3:0] index
);
    import tbs_pkg::*;
    // Sixteen equal bands of the measured code
    assign index = code[ADC_W-1:ADC_W-4];
endmodule : index_decode

//--- verif/tbs_properties.sv
`timescale 1ns/1ns
module tbs_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Sensors and comparators
    input wire logic [1:0] converter_switch_overtemp,
    input wire logic conn_supply_overtemp,
    input wire logic discharge_path_overtemp,
    input wire logic master_regulator_overtemp,
    input wire logic enable_rising_threshold,
    input wire logic enable_off_below,
    input wire logic supply_valid_threshold,
    // Outputs
    input wire logic converter_enable,
    input wire logic port_a_conn_supply,
    input wire logic discharge_switch_closed,
    input wire logic error_recovery_req,
    input wire logic processor_reset_n,
    input wire logic port_b_enable,
    input wire logic update_mode
);
    import tbs_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_conv; |converter_switch_overtemp |=>
        !converter_enable && error_recovery_req; endproperty
    a_conv: assert property (p_conv) else $error("converter on while hot");
    property p_conn; conn_supply_overtemp |=>
        !port_a_conn_supply && error_recovery_req; endproperty
    a_conn: assert property (p_conn) else $error("supply switch closed while hot");
    property p_disch; discharge_path_overtemp |=> !discharge_switch_closed; endproperty
    a_disch: assert property (p_disch) else $error("discharge closed while hot");
    property p_master; master_regulator_overtemp |=> !processor_reset_n; endproperty
    a_master: assert property (p_master) else $error("processor not reset");
    property p_cool; $fell(master_regulator_overtemp) |->
        !processor_reset_n ##1 !processor_reset_n; endproperty
    a_cool: assert property (p_cool) else $error("restart too early");
    property p_off; enable_off_below |=> !processor_reset_n; endproperty
    a_off: assert property (p_off) else $error("running while disabled");
    property p_on; $rose(processor_reset_n) |->
        $past(enable_rising_threshold && supply_valid_threshold); endproperty
    a_on: assert property (p_on) else $error("started without enable");
    property p_upd; $rose(update_mode) |-> processor_reset_n && !port_b_enable; endproperty
    a_upd: assert property (p_upd) else $error("update mode with port b");
endmodule : tbs_checker

//--- verif/sensor_model.sv
`timescale 1ns/1ns
module sensor_model (
    // Bench commands
    input wire logic [4:0] hot_cmd,
    input wire logic [2:0] en_cmd,
    input wire logic [tbs_pkg::ADC_W-1:0] bus_cmd,
    // Sensor and comparator levels
    output logic [1:0] converter_switch_overtemp,
    output logic conn_supply_overtemp,
    output logic discharge_path_overtemp,
    output logic master_regulator_overtemp,
    output logic enable_rising_threshold,
    output logic enable_off_below,
    output logic supply_valid_threshold,
    output logic [tbs_pkg::ADC_W-1:0] port_a_bus_power
);
    import tbs_pkg::*;
    // Ideal comparators, no hysteresis band: the bench steps every level cleanly
    assign {converter_switch_overtemp, conn_supply_overtemp} = hot_cmd[4:2];
    assign {discharge_path_overtemp, master_regulator_overtemp} = hot_cmd[1:0];
    assign {enable_rising_threshold, enable_off_below, supply_valid_threshold} = en_cmd;
    assign port_a_bus_power = bus_cmd;
endmodule : sensor_model

//--- verif/thermal_boot_supervisor_tb.sv
`timescale 1ns/1ns
module thermal_boot_supervisor_tb;
    import tbs_pkg::*;
    typedef struct {string nm; logic [31:0] v; logic [31:0] m;} note_t;
    note_t q[$];
    note_t nt;
    logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, rd = 0, snap = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, sd;
    logic [2:0] hsize = 3'h2, en_cmd = 3'h2;
    logic [1:0] htrans = 0, thermal_level, converter_switch_overtemp;
    logic [4:0] hot_cmd = 0;
    logic [11:0] config_select_resistor = 0, thermistor_sense = 0, bus_cmd = 0, port_a_bus_power;
    logic hready, hreadyout, hresp, converter_enable, port_a_conn_supply, discharge_switch_closed;
    logic error_recovery_req, processor_reset_n, port_b_enable, update_mode, conn_supply_overtemp;
    logic discharge_path_overtemp, master_regulator_overtemp, enable_rising_threshold;
    logic enable_off_below, supply_valid_threshold;
    int n_fail = 0, comparisons = 0, cyc = 0, i;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;
    thermal_boot_supervisor dut_u (.*);
    sensor_model sm_u (.*);
    task conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    task chk(string nm, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Held one edge past the result so back-to-back calls never double-assign a flag
    task snp(string nm, logic [6:0] e, logic [6:0] m);
        q.push_back('{nm, {25'h0, e}, {25'h0, m}});
        // One edge of margin so registered outputs launched by the last input step settle
        @(posedge hclk);
        snap <= 1;
        @(posedge hclk);
        snap <= 0;
        @(posedge hclk);
    endtask : snp
    task xfer(logic w, logic [7:0] a, logic [31:0] d);
        {htrans, hsel, haddr, hwrite} <= {2'b10, 1'b1, 24'h0, a, w};
        do @(posedge hclk); while (hready !== 1'b1);
        {htrans, hsel, hwdata, rd} <= {2'b00, 1'b0, d, !w};
        do @(posedge hclk); while (hready !== 1'b1);
        rd <= 0;
        @(posedge hclk);
    endtask : xfer
    task rdx(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m);
        q.push_back('{nm, e, m});
        xfer(0, a, 0);
    endtask : rdx
    task up();
        for (i = 0; i < 100 && processor_reset_n !== 1'b1; i++)
            @(posedge hclk);
        repeat (3) @(posedge hclk);
    endtask : up
    // Outputs are looked at mid-cycle, away from the edge that launches them
    always @(negedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
        if ((rd && hready) || snap) begin
            nt = q.pop_front();
            chk(nt.nm, (rd ? hrdata : {25'h0, converter_enable, port_a_conn_supply,
                discharge_switch_closed, error_recovery_req, processor_reset_n,
                port_b_enable, update_mode}) & nt.m, nt.v);
        end
    end
    initial begin
        sd = $urandom(32'h9045);
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        snp("rst", 0, 7'h04);
        xfer(1, 8'h1c, 32'hffff_ffff);
        rdx("unmapped", 8'h1c, 0, '1);
        rdx("th2", ADDR_NTC_TH2, {20'h0, NTC_TH2_RESET}, '1);
        en_cmd <= 3'b100;
        repeat (4) @(posedge hclk);
        snp("nosupply", 0, 7'h04);
        config_select_resistor <= {1'b0, 3'($urandom), 8'($urandom)};
        en_cmd <= 3'b101;
        up();
        rdx("load", ADDR_STATUS, {12'h0, config_select_resistor[11:8], 16'h2}, 32'hf_0007);
        xfer(1, ADDR_CTRL, 32'h1);
        snp("run", 7'h06, 7'h07);
        for (int k = 0; k < 3; k++) begin
            hot_cmd <= 5'h10 >> k;
            repeat (3) @(posedge hclk);
            snp("hot", 7'h08, k < 2 ? 7'h48 : 7'h28);
            hot_cmd <= 0;
            xfer(1, ADDR_CTRL, 32'h5);
            rdx("recov", ADDR_STATUS, 0, 32'h400);
        end
        bus_cmd <= 12'h400;
        hot_cmd <= 5'h02;
        repeat (3) @(posedge hclk);
        snp("dis_hot", 0, 7'h10);
        hot_cmd <= 0;
        repeat (3) @(posedge hclk);
        snp("dis_flat", 0, 7'h10);
        bus_cmd <= 12'h3f0;
        repeat (3) @(posedge hclk);
        snp("dis_fall", 7'h10, 7'h10);
        for (int k = 0; k < 4; k++) begin
            thermistor_sense <= 12'h700 + 12'(k * 'h200) + 12'($urandom % 256);
            repeat (3) @(posedge hclk);
            rdx("level", ADDR_STATUS, 32'(k) << 12, 32'h3000);
        end
        hot_cmd <= 5'h01;
        repeat (3) @(posedge hclk);
        rdx("latch", ADDR_STATUS, 32'h200, 32'h207);
        hot_cmd <= 0;
        up();
        xfer(1, ADDR_CTRL, 32'h2);
        rdx("fallback", ADDR_STATUS, 32'h4, 32'h7);
        snp("porta", 7'h04, 7'h07);
        en_cmd <= 3'b010;
        repeat (3) @(posedge hclk);
        config_select_resistor <= {UPDATE_INDEX, 8'($urandom)};
        en_cmd <= 3'b101;
        up();
        rdx("update", ADDR_STATUS, 32'h5, 32'h7);
        snp("upd", 7'h05, 7'h07);
        conclude();
    end
endmodule : thermal_boot_supervisor_tb
bind thermal_boot_supervisor tbs_checker chk_u (.*);
